// ---- common/dac_sf_map.svh ----
// dac_sf_map.svh: command codes, field positions, reset values for the
// special-function decoder.
// assumes the serial framer has already split each frame into a 6-bit
// special-function code and a 16-bit data field F15..F0.
`ifndef DAC_SF_MAP_SVH
`define DAC_SF_MAP_SVH

// ----------------------------------------------------------------------
// special-function codes
// ----------------------------------------------------------------------
`define SF_RB_SELECT      6'h05
`define SF_BANK_LOW_WR    6'h06
`define SF_BANK_HIGH_WR   6'h07
`define SF_BANK_BLOCK_WR  6'h0b
`define SF_MON_CFG        6'h0c
`define SF_GPIO_CFG       6'h0d

// ----------------------------------------------------------------------
// field positions inside F15..F0
// ----------------------------------------------------------------------
`define MON_EN_BIT        5
`define MON_SRC_BIT       4
`define MON_CHAN_HI       3
`define MON_CHAN_LO       0
`define MON_IN_BIT        0
`define GPIO_DIR_BIT      1
`define GPIO_VAL_BIT      0
`define RB_GLOBAL_BIT     15
`define RB_KIND_HI        14
`define RB_KIND_LO        13
`define RB_CHAN_HI        12
`define RB_CHAN_LO        7
`define RB_GIDX_HI        14
`define RB_GIDX_LO        7

// ----------------------------------------------------------------------
// readback address values
// ----------------------------------------------------------------------
`define RB_CHAN_FIRST     6'h08
`define RB_CHAN_LAST      6'h17
`define GIDX_CONTROL      8'h01
`define GIDX_OFS_ZERO     8'h02
`define GIDX_OFS_ONE      8'h03
`define GIDX_BANK_LOW     8'h06
`define GIDX_BANK_HIGH    8'h07
`define GIDX_GPIO         8'h0b

// ----------------------------------------------------------------------
// reset values and the block-write all-ones pattern
// ----------------------------------------------------------------------
`define BANK_RESET        8'h00
`define BANK_ALL_ONES     8'hff
`define MON_CHAN_RESET    4'h0
`define RB_DATA_RESET     16'h0000

`endif

// ---- common/dac_sf_pkg.sv ----
// dac_sf_pkg: types shared by the special-function decoder files.
// assumes nothing beyond a SystemVerilog compiler.
package dac_sf_pkg;

  // readback target class; codes 000..011 follow F14..F13
  typedef enum logic [2:0] {
    RB_DATA_A  = 3'b000,
    RB_DATA_B  = 3'b001,
    RB_OFFSET  = 3'b010,
    RB_GAIN    = 3'b011,
    RB_GLOBAL  = 3'b100,
    RB_INVALID = 3'b111
  } rb_kind_e;

  // one decoded special-function frame
  typedef struct packed {
    logic [5:0]  code;
    logic [15:0] data;
  } sf_cmd_s;

  // monitor multiplexer setting
  typedef struct packed {
    logic       enable;
    logic       use_input;
    logic       input_second;
    logic [3:0] channel;
  } mon_cfg_s;

  // readback address
  typedef struct packed {
    rb_kind_e   kind;
    logic [3:0] channel;
    logic [7:0] gindex;
  } rb_addr_s;

endpackage

// ---- logic/rb_address_decode.sv ----
// rb_address_decode: turns the readback-select data field into a target.
// assumes a valid field; purely combinational, caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "dac_sf_map.svh"

module rb_address_decode (
  input  wire logic [15:0]        field_i,  // readback-select F15..F0
  output var  dac_sf_pkg::rb_addr_s addr_o  // decoded readback target
);
  import dac_sf_pkg::*;

  logic [5:0] chan_code;
  logic [5:0] chan_off;

  // ----------------------------------------------------------------------
  // field split; F6..F0 never enter the decode
  // ----------------------------------------------------------------------
  assign chan_code = field_i[`RB_CHAN_HI:`RB_CHAN_LO];
  assign chan_off  = chan_code - `RB_CHAN_FIRST;

  // channel codes outside 8..23 are marked invalid rather than wrapped
  always_comb begin
    addr_o = '{kind: RB_INVALID, channel: 4'h0, gindex: 8'h00};
    if (field_i[`RB_GLOBAL_BIT]) begin
      addr_o.kind   = RB_GLOBAL;
      addr_o.gindex = field_i[`RB_GIDX_HI:`RB_GIDX_LO];
    end else if (chan_code >= `RB_CHAN_FIRST && chan_code <= `RB_CHAN_LAST) begin
      addr_o.kind    = rb_kind_e'({1'b0, field_i[`RB_KIND_HI:`RB_KIND_LO]});
      addr_o.channel = chan_off[3:0];
    end
  end

endmodule  // rb_address_decode
`default_nettype wire

// ---- logic/dac_special_function_decode.sv ----
// dac_special_function_decode: monitor, gpio, bank-select and readback
// address handling for a 16-channel serial-programmed converter.
// assumes a framer on clock_i delivering one command per frame and a
// frame-start pulse; per-channel and control words come from outside.
`timescale 1ns/1ps
`default_nettype none
`include "dac_sf_map.svh"

module dac_special_function_decode (
  input  wire logic                  clock_i,           // serial domain clock
  input  wire logic                  reset_n_i,         // sync reset, active low
  input  wire dac_sf_pkg::sf_cmd_s   cmd_i,             // decoded frame
  input  wire logic                  cmd_valid_i,       // one-cycle frame strobe
  input  wire logic                  frame_start_i,     // one-cycle frame start
  input  wire logic                  gpio_i,            // gpio pin level
  output logic                       gpio_o,            // gpio drive value
  output logic                       gpio_oe_o,         // gpio drive enable
  output var dac_sf_pkg::mon_cfg_s   mon_cfg_o,         // monitor mux setting
  output logic [15:0]                data_sel_second_o, // per channel bank pick
  output var dac_sf_pkg::rb_addr_s   rb_addr_o,         // readback target
  input  wire logic [15:0]           ext_rd_data_i,     // word at rb_addr_o
  output logic [15:0]                rb_data_o,         // word for this frame
  output logic                       rb_active_o        // rb_data_o valid
);
  import dac_sf_pkg::*;

  logic       gpio_meta;
  logic       gpio_level;
  logic [7:0] sel_low;
  logic [7:0] sel_high;
  logic       rb_pending;
  rb_addr_s   next_rb_addr;
  logic [15:0] next_rb_data;
  logic       is_mon;
  logic       is_gpio;
  logic       is_rbsel;

  assign is_mon   = cmd_valid_i && cmd_i.code == `SF_MON_CFG;
  assign is_gpio  = cmd_valid_i && cmd_i.code == `SF_GPIO_CFG;
  assign is_rbsel = cmd_valid_i && cmd_i.code == `SF_RB_SELECT;

  // ----------------------------------------------------------------------
  // gpio pin
  // ----------------------------------------------------------------------
  // pin level crosses in from outside; only the second stage is read
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      gpio_meta  <= 1'b0;
      gpio_level <= 1'b0;
    end else begin
      gpio_meta  <= gpio_i;
      gpio_level <= gpio_meta;
    end
  end

  // direction and value; pin comes up as input so nothing fights on power-up
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      gpio_oe_o <= 1'b0;
      gpio_o    <= 1'b0;
    end else if (is_gpio) begin
      gpio_oe_o <= cmd_i.data[`GPIO_DIR_BIT];
      if (cmd_i.data[`GPIO_DIR_BIT])
        gpio_o <= cmd_i.data[`GPIO_VAL_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // monitor multiplexer
  // ----------------------------------------------------------------------
  // F15..F6 are never looked at; unused fields keep their old value
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      mon_cfg_o <= '{enable: 1'b0, use_input: 1'b0, input_second: 1'b0,
                     channel: `MON_CHAN_RESET};
    end else if (is_mon) begin
      mon_cfg_o.enable    <= cmd_i.data[`MON_EN_BIT];
      mon_cfg_o.use_input <= cmd_i.data[`MON_SRC_BIT];
      if (!cmd_i.data[`MON_SRC_BIT])
        mon_cfg_o.channel <= cmd_i.data[`MON_CHAN_HI:`MON_CHAN_LO];
      else if (cmd_i.data[`MON_EN_BIT])
        mon_cfg_o.input_second <= cmd_i.data[`MON_IN_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // bank select registers
  // ----------------------------------------------------------------------
  // block write only acts on all-zero or all-one data, other patterns ignored
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sel_low  <= `BANK_RESET;
      sel_high <= `BANK_RESET;
    end else if (cmd_valid_i) begin
      if (cmd_i.code == `SF_BANK_LOW_WR)
        sel_low <= cmd_i.data[7:0];
      if (cmd_i.code == `SF_BANK_HIGH_WR)
        sel_high <= cmd_i.data[7:0];
      if (cmd_i.code == `SF_BANK_BLOCK_WR &&
          (cmd_i.data[7:0] == `BANK_RESET || cmd_i.data[7:0] == `BANK_ALL_ONES)) begin
        sel_low  <= cmd_i.data[7:0];
        sel_high <= cmd_i.data[7:0];
      end
    end
  end

  // bit n set sends channel n to its second input register
  assign data_sel_second_o = {sel_high, sel_low};

  // ----------------------------------------------------------------------
  // readback address and data
  // ----------------------------------------------------------------------
  rb_address_decode u_rb_decode (
    .field_i (cmd_i.data),
    .addr_o  (next_rb_addr)
  );

  // address is held so the outside register file can settle before frame start
  always_ff @(posedge clock_i) begin
    if (!reset_n_i)
      rb_addr_o <= '{kind: RB_INVALID, channel: 4'h0, gindex: 8'h00};
    else if (is_rbsel)
      rb_addr_o <= next_rb_addr;
  end

  // word source; reserved and bad addresses read as zero
  always_comb begin
    next_rb_data = `RB_DATA_RESET;
    unique case (rb_addr_o.kind)
      RB_DATA_A, RB_DATA_B, RB_OFFSET, RB_GAIN: next_rb_data = ext_rd_data_i;
      RB_GLOBAL: begin
        case (rb_addr_o.gindex)
          `GIDX_CONTROL, `GIDX_OFS_ZERO, `GIDX_OFS_ONE: next_rb_data = ext_rd_data_i;
          `GIDX_BANK_LOW:  next_rb_data = {8'h00, sel_low};
          `GIDX_BANK_HIGH: next_rb_data = {8'h00, sel_high};
          `GIDX_GPIO:      next_rb_data = {15'h0000, gpio_level};
          default:         next_rb_data = `RB_DATA_RESET;
        endcase
      end
      default: next_rb_data = `RB_DATA_RESET;
    endcase
  end

  // request waits for the next frame start; a new select in the same
  // cycle wins over the clear so it is served on the frame after
  always_ff @(posedge clock_i) begin
    if (!reset_n_i)
      rb_pending <= 1'b0;
    else if (is_rbsel)
      rb_pending <= 1'b1;
    else if (frame_start_i)
      rb_pending <= 1'b0;
  end

  // data is frozen for a whole frame; commands in it still decode normally
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rb_data_o   <= `RB_DATA_RESET;
      rb_active_o <= 1'b0;
    end else if (frame_start_i) begin
      rb_active_o <= rb_pending;
      if (rb_pending)
        rb_data_o <= next_rb_data;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_select;
    is_rbsel;
  endsequence

  sequence s_next_frame;
    !is_rbsel && frame_start_i;
  endsequence

  // one idle cycle between select and frame start, as a host leaves it
  sequence s_quiet;
    !is_rbsel && !frame_start_i;
  endsequence

  property p_mon_enable;
    is_mon |=> mon_cfg_o.enable == $past(cmd_i.data[5]);
  endproperty
  a_mon_enable: assert property (p_mon_enable) else $error("monitor enable wrong");

  property p_mon_channel;
    is_mon && !cmd_i.data[4] |=> !mon_cfg_o.use_input && mon_cfg_o.channel == $past(cmd_i.data[3:0]);
  endproperty
  a_mon_channel: assert property (p_mon_channel) else $error("monitor channel wrong");

  property p_mon_input;
    is_mon && cmd_i.data[5:4] == 2'b11
      |=> mon_cfg_o.use_input && mon_cfg_o.input_second == $past(cmd_i.data[0]);
  endproperty
  a_mon_input: assert property (p_mon_input) else $error("monitor input wrong");

  property p_mon_ignore;
    is_mon && cmd_i.data[4] |=> $stable(mon_cfg_o.channel);
  endproperty
  a_mon_ignore: assert property (p_mon_ignore) else $error("monitor channel moved");

  property p_gpio_out;
    is_gpio && cmd_i.data[1] |=> gpio_oe_o && gpio_o == $past(cmd_i.data[0]);
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("gpio output wrong");

  property p_gpio_in;
    is_gpio && !cmd_i.data[1] |=> !gpio_oe_o && $stable(gpio_o);
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("gpio not input");

  property p_rb_channel;
    is_rbsel && !cmd_i.data[15] && cmd_i.data[12:7] == 6'h17
      |=> rb_addr_o.channel == 4'hf && rb_addr_o.kind == rb_kind_e'({1'b0, $past(cmd_i.data[14:13])});
  endproperty
  a_rb_channel: assert property (p_rb_channel) else $error("channel decode wrong");

  property p_rb_global;
    is_rbsel && cmd_i.data[15] |=> rb_addr_o.kind == RB_GLOBAL && rb_addr_o.gindex == $past(cmd_i.data[14:7]);
  endproperty
  a_rb_global: assert property (p_rb_global) else $error("global decode wrong");

  property p_bank_low;
    cmd_valid_i && cmd_i.code == `SF_BANK_LOW_WR
      |=> data_sel_second_o[7:0] == $past(cmd_i.data[7:0]) && $stable(data_sel_second_o[15:8]);
  endproperty
  a_bank_low: assert property (p_bank_low) else $error("low bank select wrong");

  property p_rb_next_frame;
    s_select ##1 s_quiet ##1 s_next_frame |=> rb_active_o && !rb_pending;
  endproperty
  a_rb_next_frame: assert property (p_rb_next_frame) else $error("readback not served");

  property p_rb_gpio;
    frame_start_i && rb_pending && rb_addr_o.kind == RB_GLOBAL && rb_addr_o.gindex == 8'h0b
      |=> rb_data_o == {15'h0000, $past(gpio_level)};
  endproperty
  a_rb_gpio: assert property (p_rb_gpio) else $error("gpio readback wrong");

endmodule  // dac_special_function_decode
`default_nettype wire

// ---- test/sf_host_model.sv ----
// sf_host_model: serial host that hands framed commands to the decoder.
// assumes callers enter its tasks at a falling edge of clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "dac_sf_map.svh"

module sf_host_model (
  input  wire logic                clock_i,       // decoder clock
  output var  dac_sf_pkg::sf_cmd_s cmd_o,         // command word
  output logic                     cmd_valid_o,   // one-cycle command strobe
  output logic                     frame_start_o  // one-cycle frame start
);
  import dac_sf_pkg::*;

  // idle state at time zero
  initial begin
    cmd_o = '0;
    cmd_valid_o = 1'b0;
    frame_start_o = 1'b0;
  end

  // one command, then gap + 1 idle cycles; the bus is inverted once released
  // so a decoder that reads stale words is caught
  task automatic send(input logic [5:0] code, input logic [15:0] data, input int gap);
    cmd_o = '{code: code, data: data};
    cmd_valid_o = 1'b1;
    @(negedge clock_i);
    cmd_valid_o = 1'b0;
    cmd_o = ~cmd_o;
    repeat (gap + 1) @(negedge clock_i);
  endtask

  // pin readback select with the unused low field cleared
  task automatic sel_gpio();
    send(`SF_RB_SELECT, 16'h8580, 0);
  endtask

  // start of a serial frame
  task automatic frame();
    frame_start_o = 1'b1;
    @(negedge clock_i);
    frame_start_o = 1'b0;
  endtask
endmodule // sf_host_model

`default_nettype wire

// ---- test/tb.sv ----
// tb: self-checking bench for the special-function decoder.
// assumes the host model drives commands; bench drives pin and ext word.
`timescale 1ns/1ps
`default_nettype none
`include "dac_sf_map.svh"

module tb;
  import dac_sf_pkg::*;
  logic        clock_i, reset_n_i, gpio_i, gpio_o, gpio_oe_o, cmd_valid, frame_start, rb_act;
  sf_cmd_s     cmd;
  mon_cfg_s    mon, exp_mon;
  rb_addr_s    rb_addr;
  logic [15:0] sel2, ext, rb_data, exp_bank;
  logic [15:0] corner [4] = '{16'h0020, 16'h002f, 16'h003e, 16'h0031};
  logic [7:0]  gtab [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h0b};
  int          num_errors = 0, checked = 0, cycles = 0;

  sf_host_model host (.clock_i(clock_i), .cmd_o(cmd), .cmd_valid_o(cmd_valid),
                      .frame_start_o(frame_start));
  dac_special_function_decode u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .cmd_i(cmd),
    .cmd_valid_i(cmd_valid), .frame_start_i(frame_start), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe_o(gpio_oe_o), .mon_cfg_o(mon), .data_sel_second_o(sel2), .rb_addr_o(rb_addr),
    .ext_rd_data_i(ext), .rb_data_o(rb_data), .rb_active_o(rb_act));

  // ----------------------------------------------------------------------
  // expectation functions
  // ----------------------------------------------------------------------
  function automatic mon_cfg_s next_mon(mon_cfg_s m, logic [15:0] f);
    next_mon = m;
    next_mon.enable = f[5];
    next_mon.use_input = f[4];
    if (f[4] && f[5]) next_mon.input_second = f[0];
    if (!f[4]) next_mon.channel = f[3:0];
  endfunction

  function automatic rb_kind_e kind_expect(logic [15:0] f);
    if (f[15]) return RB_GLOBAL;
    if (f[12:7] < 6'h08 || f[12:7] > 6'h17) return RB_INVALID;
    return rb_kind_e'({1'b0, f[14:13]});
  endfunction

  function automatic logic [15:0] rb_expect(logic [15:0] f, logic [15:0] x, logic [15:0] b,
                                            logic g);
    if (!f[15]) return (f[12:7] >= 6'h08 && f[12:7] <= 6'h17) ? x : 16'h0000;
    case (f[14:7])
      8'h01, 8'h02, 8'h03: return x;
      8'h06: return {8'h00, b[7:0]};
      8'h07: return {8'h00, b[15:8]};
      8'h0b: return {15'h0000, g};
      default: return 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // 8 ns clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // hang guard, well above the roughly 500 cycles the run needs
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [15:0] f, m;
    logic [5:0]  code;
    void'($urandom(32'h6136e8b8));
    reset_n_i = 1'b0;
    gpio_i = 1'b0;
    ext = 16'h0000;
    repeat (2) @(negedge clock_i);
    chk(gpio_oe_o === 1'b0 && mon === '0 && sel2 === 16'h0000 && rb_addr.kind === RB_INVALID
        && rb_act === 1'b0 && rb_data === 16'h0000, "reset state");
    reset_n_i = 1'b1;
    @(negedge clock_i);
    // monitor: corners first, then random fields including ignored bits
    exp_mon = '0;
    for (int i = 0; i < 44; i++) begin
      f = (i < 4) ? corner[i] : 16'($urandom);
      exp_mon = next_mon(exp_mon, f);
      host.send(`SF_MON_CFG, f, i % 3);
      chk(mon === exp_mon, "monitor setting");
    end
    // pin direction and drive, then pin level read back next frame
    for (int i = 0; i < 8; i++) begin
      f = 16'($urandom);
      gpio_i = f[2];
      host.send(`SF_GPIO_CFG, f, 0);
      chk(gpio_oe_o === f[1] && (f[1] == 1'b0 || gpio_o === f[0]), "pin drive");
      // a driven pin shows its own drive level, so no fight with the bench
      gpio_i = f[1] ? f[0] : f[2];
      host.sel_gpio();
      chk(rb_addr.kind === RB_GLOBAL && rb_addr.gindex === 8'h0b, "pin select");
      host.frame();
      chk(rb_data === {15'h0000, (f[1] ? f[0] : f[2])} && rb_act === 1'b1, "pin readback");
    end
    // bank select registers: single writes and block writes, legal or not
    exp_bank = 16'h0000;
    for (int i = 0; i < 27; i++) begin
      f = 16'($urandom);
      code = (i % 3 == 0) ? `SF_BANK_LOW_WR : (i % 3 == 1) ? `SF_BANK_HIGH_WR : `SF_BANK_BLOCK_WR;
      if (code == `SF_BANK_BLOCK_WR && (i / 3) % 3 != 2) f[7:0] = (i % 2) ? 8'hff : 8'h00;
      case (code)
        `SF_BANK_LOW_WR: exp_bank[7:0] = f[7:0];
        `SF_BANK_HIGH_WR: exp_bank[15:8] = f[7:0];
        default: if (f[7:0] == 8'h00 || f[7:0] == 8'hff) exp_bank = {2{f[7:0]}};
      endcase
      host.send(code, f, i % 2);
      chk(sel2 === exp_bank, "bank select");
    end
    // pin back to input so the bench may drive its level below
    host.send(`SF_GPIO_CFG, 16'h0000, 0);
    chk(gpio_oe_o === 1'b0, "pin input");
    // readback: global table, valid channels, raw random addresses
    for (int i = 0; i < 48; i++) begin
      f = 16'($urandom);
      if (i % 4 == 0) f[15:7] = {1'b1, gtab[(i / 4) % 8]};
      if (i % 4 == 0 && f[14:7] == 8'h0b) f[6:0] = 7'h00;
      if (i % 4 == 1 || i % 4 == 2) f[15:7] = {1'b0, f[14:13], 6'h08 + 6'($urandom % 16)};
      // channel end points always visited
      if (i == 1 || i == 2) f[12:7] = (i == 1) ? 6'h17 : 6'h08;
      ext = 16'($urandom);
      gpio_i = f[3];
      host.send(`SF_RB_SELECT, f, 0);
      chk(rb_addr.kind === kind_expect(f), "readback kind");
      if (f[15]) chk(rb_addr.gindex === f[14:7], "global index");
      else if (kind_expect(f) != RB_INVALID) chk(rb_addr.channel === 4'(f[12:7] - 6'h08),
                                                  "readback channel");
      host.frame();
      chk(rb_data === rb_expect(f, ext, exp_bank, f[3]) && rb_act === 1'b1,
          "readback word");
      // a command inside the frame decodes while the readback word stays frozen
      m = 16'($urandom);
      exp_mon = next_mon(exp_mon, m);
      host.send(`SF_MON_CFG, m, 0);
      chk(mon === exp_mon && rb_act === 1'b1 && rb_data === rb_expect(f, ext, exp_bank, f[3]),
          "frame command");
    end
    host.frame();
    chk(rb_act === 1'b0, "no pending select");
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire
